//--- core/pot_host_ctrl.v
`include "pot_host_consts.vh"
module pot_host_ctrl #(
  parameter PWRUP_CYCLES = (`PWRUP_US * 1000 + `CLK_NS - 1) / `CLK_NS,
  parameter [3:0] TYPE_CODE = 4'ha // arbitrary value, set per system
) (
  input wire CLK_SYS,
  input wire RST_N,
  input wire [7:0] WB_ADR_I,
  input wire [31:0] WB_DAT_I,
  output reg [31:0] WB_DAT_O,
  input wire WB_WE_I,
  input wire [3:0] WB_SEL_I,
  input wire WB_CYC_I,
  input wire WB_STB_I,
  output reg WB_ACK_O,
  input wire SCL_I,
  output reg SCL_O,
  output reg SCL_OE_N,
  input wire SDA_I,
  output reg SDA_O,
  output reg SDA_OE_N,
  output reg WP_N
);
  localparam PHASE_CYC = (`PHASE_NS + `CLK_NS - 1) / `CLK_NS;
  localparam [8:0] CTRL_RST = `CTRL_RESET;
  localparam [4:0] S_IDLE = 5'b00001;
  localparam [4:0] S_START = 5'b00010;
  localparam [4:0] S_BIT = 5'b00100;
  localparam [4:0] S_STOP = 5'b01000;
  localparam [4:0] S_BUF = 5'b10000;

  reg [4:0] state;
  reg [1:0] phase;
  reg [3:0] bitcnt;
  reg [1:0] byte_idx;
  reg [7:0] shift;
  reg [3:0] strap;
  reg [1:0] len;
  reg rd;
  reg [7:0] instr;
  reg [7:0] wdata;
  reg [7:0] rxdata;
  reg pend;
  reg busy;
  reg nack;
  reg done;
  reg ready;
  reg [16:0] pwr_cnt;
  reg [31:0] ctrl_word;
  reg [31:0] status_word;
  wire tick;
  wire [1:0] pins_s;
  wire scl_s = pins_s[1];
  wire sda_s = pins_s[0];
  wire rx_byte = rd && (byte_idx == 2'd2);
  wire last_byte = (byte_idx == len - 2'd1);
  wire sel = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  // writes land at the edge where the master samples ack, never earlier
  wire wr = WB_CYC_I && WB_STB_I && WB_WE_I && WB_ACK_O;

  // which register an address names; used by read and write paths
  function [1:0] reg_of;
    input [7:0] a;
    begin
      case (a)
        `OFS_CTRL: reg_of = 2'd1;
        `OFS_TXDATA: reg_of = 2'd2;
        `OFS_STATUS: reg_of = 2'd3;
        default: reg_of = 2'd0;
      endcase
    end
  endfunction

  // level that the master pulls for this bit: 1 means pull low
  function pull_low;
    input is_rx;
    input [3:0] b;
    input [7:0] sh;
    input last;
    begin
      if (is_rx)
        pull_low = (b == 4'd8) && !last;
      else
        pull_low = (b != 4'd8) && !sh[7];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  pot_sync2 #(.W(2)) u_sync (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .d({SCL_I, SDA_I}),
    .q(pins_s)
  );

  pot_tick #(.N(PHASE_CYC), .W(8)) u_tick (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .run(state != S_IDLE),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // power-up hold-off before the first transfer
  always @(posedge CLK_SYS) begin
    if (!RST_N) begin
      pwr_cnt <= 17'h00000;
      ready <= 1'b0;
    end else if (!ready) begin
      if (pwr_cnt == PWRUP_CYCLES[16:0] - 17'h00001)
        ready <= 1'b1;
      else
        pwr_cnt <= pwr_cnt + 17'h00001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control and status words as software sees them; go reads as zero
  always @* begin
    ctrl_word = 32'h00000000;
    ctrl_word[`CTRL_STRAP_LSB +: 4] = strap;
    ctrl_word[`CTRL_LEN_LSB +: 2] = len;
    ctrl_word[`CTRL_READ_BIT] = rd;
    ctrl_word[`CTRL_WP_N_BIT] = WP_N;
    status_word = 32'h00000000;
    status_word[`STAT_BUSY_BIT] = busy;
    status_word[`STAT_NACK_BIT] = nack;
    status_word[`STAT_DONE_BIT] = done;
    status_word[`STAT_READY_BIT] = ready;
    status_word[`STAT_RX_LSB +: 8] = rxdata;
  end

  ////////////////////////////////////////////////////////////////////////
  // wishbone slave: ack one cycle after the strobe, unmapped reads zero
  always @(posedge CLK_SYS) begin
    if (!RST_N) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h00000000;
      strap <= CTRL_RST[3:0];
      len <= CTRL_RST[5:4];
      rd <= CTRL_RST[6];
      WP_N <= CTRL_RST[8];
      instr <= 8'h00;
      wdata <= 8'h00;
    end else begin
      WB_ACK_O <= sel;
      WB_DAT_O <= 32'h00000000;
      if (sel && !WB_WE_I) begin
        case (reg_of(WB_ADR_I))
          2'd1: WB_DAT_O <= ctrl_word;
          2'd2: WB_DAT_O <= {16'h0000, instr, wdata};
          2'd3: WB_DAT_O <= status_word;
          default: WB_DAT_O <= 32'h00000000;
        endcase
      end
      // settings other than WP_N are frozen while a transfer runs
      if (wr && reg_of(WB_ADR_I) == 2'd1) begin
        if (WB_SEL_I[1])
          WP_N <= WB_DAT_I[`CTRL_WP_N_BIT];
        if (WB_SEL_I[0] && !busy && !pend) begin
          strap <= WB_DAT_I[3:0];
          len <= (WB_DAT_I[5:4] == 2'd0) ? 2'd1 : WB_DAT_I[5:4];
          rd <= WB_DAT_I[`CTRL_READ_BIT];
        end
      end
      if (wr && reg_of(WB_ADR_I) == 2'd2 && !busy && !pend) begin
        if (WB_SEL_I[1])
          instr <= WB_DAT_I[15:8];
        if (WB_SEL_I[0])
          wdata <= WB_DAT_I[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // two-wire engine: four phases per bit, clock low for two, high for two
  always @(posedge CLK_SYS) begin
    if (!RST_N) begin
      state <= S_IDLE;
      phase <= 2'd0;
      bitcnt <= 4'd0;
      byte_idx <= 2'd0;
      shift <= 8'h00;
      rxdata <= 8'h00;
      pend <= 1'b0;
      busy <= 1'b0;
      nack <= 1'b0;
      done <= 1'b0;
      SCL_O <= 1'b0;
      SDA_O <= 1'b0;
      SCL_OE_N <= 1'b1;
      SDA_OE_N <= 1'b1;
    end else begin
      SCL_O <= 1'b0; // open drain: only ever pulled low
      SDA_O <= 1'b0;
      if (wr && reg_of(WB_ADR_I) == 2'd1 && WB_SEL_I[0]
          && WB_DAT_I[`CTRL_GO_BIT] && !busy)
        pend <= 1'b1;
      if (tick)
        phase <= phase + 2'd1;
      case (state)
        S_IDLE: begin
          // launch only on an idle bus after the power-up wait
          if (pend && ready && scl_s && sda_s) begin
            pend <= 1'b0;
            busy <= 1'b1;
            nack <= 1'b0;
            done <= 1'b0;
            phase <= 2'd0;
            bitcnt <= 4'd0;
            byte_idx <= 2'd0;
            shift <= {TYPE_CODE, strap};
            state <= S_START;
          end
        end
        S_START: begin
          if (tick && phase == 2'd1)
            SDA_OE_N <= 1'b0; // falls with clock high
          if (tick && phase == 2'd3) begin
            SCL_OE_N <= 1'b0;
            state <= S_BIT;
          end
        end
        S_BIT: begin
          // data set in the low half only
          if (tick && phase == 2'd0)
            SDA_OE_N <= !pull_low(rx_byte, bitcnt, shift, last_byte);
          if (tick && phase == 2'd1)
            SCL_OE_N <= 1'b1;
          if (tick && phase == 2'd3) begin
            SCL_OE_N <= 1'b0;
            if (bitcnt != 4'd8) begin
              shift <= {shift[6:0], sda_s};
              bitcnt <= bitcnt + 4'd1;
            end else begin
              bitcnt <= 4'd0;
              if (rx_byte)
                rxdata <= shift;
              if (!rx_byte && sda_s) begin
                // no ack: busy programming, protected or absent
                nack <= 1'b1;
                state <= S_STOP;
              end else if (last_byte) begin
                state <= S_STOP;
              end else begin
                byte_idx <= byte_idx + 2'd1;
                shift <= (byte_idx == 2'd0) ? instr : wdata;
              end
            end
          end
        end
        S_STOP: begin
          if (tick && phase == 2'd0)
            SDA_OE_N <= 1'b0;
          if (tick && phase == 2'd1)
            SCL_OE_N <= 1'b1;
          if (tick && phase == 2'd3) begin
            SDA_OE_N <= 1'b1; // rises with clock high
            state <= S_BUF;
          end
        end
        S_BUF: begin
          // bus free time before the next start
          if (tick && phase == 2'd3) begin
            busy <= 1'b0;
            done <= 1'b1;
            state <= S_IDLE;
          end
        end
        default: begin
          state <= S_IDLE;
          SCL_OE_N <= 1'b1;
          SDA_OE_N <= 1'b1;
        end
      endcase
    end
  end
endmodule // pot_host_ctrl

//--- core/pot_host_consts.vh
`ifndef POT_HOST_CONSTS_VH
`define POT_HOST_CONSTS_VH
// register byte offsets
`define OFS_CTRL 8'h00
`define OFS_TXDATA 8'h04
`define OFS_STATUS 8'h08
// control register fields
`define CTRL_STRAP_LSB 0
`define CTRL_LEN_LSB 4
`define CTRL_READ_BIT 6
`define CTRL_GO_BIT 7
`define CTRL_WP_N_BIT 8
`define CTRL_RESET 9'h130
// status register fields
`define STAT_BUSY_BIT 0
`define STAT_NACK_BIT 1
`define STAT_DONE_BIT 2
`define STAT_READY_BIT 3
`define STAT_RX_LSB 8
// timing figures
`define CLK_NS 8
`define PHASE_NS 650
`define PWRUP_US 1000
`endif

//--- core/pot_sync2.v
// two-flop synchroniser for pin inputs, idle high
module pot_sync2 #(
  parameter W = 2
) (
  input wire clk,
  input wire rst_n,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta;

  // first stage feeds only the second stage
  always @(posedge clk) begin
    if (!rst_n) begin
      meta <= {W{1'b1}};
      q <= {W{1'b1}};
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // pot_sync2

//--- core/pot_tick.v
// divider: one-cycle tick every N cycles while run is high
module pot_tick #(
  parameter N = 82,
  parameter W = 8
) (
  input wire clk,
  input wire rst_n,
  input wire run,
  output reg tick
);
  reg [W-1:0] cnt;

  // restart from zero whenever the engine is idle
  always @(posedge clk) begin
    if (!rst_n || !run) begin
      cnt <= {W{1'b0}};
      tick <= 1'b0;
    end else if (cnt == N[W-1:0] - 1'b1) begin
      cnt <= {W{1'b0}};
      tick <= 1'b1;
    end else begin
      cnt <= cnt + 1'b1;
      tick <= 1'b0;
    end
  end
endmodule // pot_tick

//--- verification/pot_host_ctrl_assertions.sv
module pot_host_ctrl_assertions #(
  parameter PWRUP_CYCLES = 200
) (
  input wire CLK_SYS,
  input wire RST_N,
  input wire [7:0] WB_ADR_I,
  input wire [31:0] WB_DAT_I,
  input wire [31:0] WB_DAT_O,
  input wire WB_WE_I,
  input wire [3:0] WB_SEL_I,
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire WB_ACK_O,
  input wire SCL_I,
  input wire SCL_O,
  input wire SCL_OE_N,
  input wire SDA_I,
  input wire SDA_O,
  input wire SDA_OE_N,
  input wire WP_N
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] bitc;
  int up;
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_N);
  ////////////////////////////////////////
  // age since reset, and clock index in a byte (start restarts it)
  always @(posedge CLK_SYS) begin
    if (!RST_N) up <= 0;
    else if (up < PWRUP_CYCLES) up <= up + 1;
    if (!RST_N || ($fell(SDA_OE_N) && SCL_OE_N)) bitc <= 4'h0;
    else if ($rose(SCL_OE_N)) bitc <= (bitc == 4'h8) ? 4'h0 : bitc + 4'h1;
  end
  ////////////////////////////////////////
  a_pins_low: assert property (!SCL_O && !SDA_O)
    else $error("pin driven high");
  a_data_hold: assert property (
    $rose(SCL_OE_N) |=> $stable(SDA_OE_N) [*8])
    else $error("data moved with clock high");
  // the wire already follows the pull at the fell edge, so look one back
  a_start_idle: assert property (
    $fell(SDA_OE_N) && SCL_OE_N |-> $past(SCL_I) && $past(SDA_I))
    else $error("start on busy bus");
  a_ninth_free: assert property (
    $rose(SCL_OE_N) && bitc == 4'h8 |-> SDA_OE_N)
    else $error("data held on ninth clock");
  a_stop_free: assert property (
    $rose(SDA_OE_N) && $past(SCL_OE_N) && SCL_OE_N |=> SCL_OE_N [*8])
    else $error("clock pulled after stop");
  a_wait_power: assert property (
    up < PWRUP_CYCLES |-> SDA_OE_N && SCL_OE_N)
    else $error("bus used before power-up delay");
  a_wb_answer: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("no ack");
  a_wb_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack too long");
  c_start: cover property ($fell(SDA_OE_N) && SCL_OE_N);
  c_ninth: cover property ($rose(SCL_OE_N) && bitc == 4'h8);
  c_stop: cover property ($rose(SDA_OE_N) && SCL_OE_N);
endmodule // pot_host_ctrl_assertions
bind pot_host_ctrl pot_host_ctrl_assertions #(.PWRUP_CYCLES(PWRUP_CYCLES))
  i_chk (.CLK_SYS, .RST_N, .WB_ADR_I, .WB_DAT_I, .WB_DAT_O, .WB_WE_I,
  .WB_SEL_I, .WB_CYC_I, .WB_STB_I, .WB_ACK_O, .SCL_I, .SCL_O, .SCL_OE_N,
  .SDA_I, .SDA_O, .SDA_OE_N, .WP_N);

//--- verification/pot_dev_model.sv
module pot_dev_model #(
  parameter [3:0] TYPE = 4'ha, // arbitrary value
  parameter [3:0] STRAP = 4'h3,
  parameter PROG = 8000
) (
  input wire clk,
  input wire scl,
  input wire sda,
  input wire wp_n,
  output logic oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  int n = 0;
  int k = 0;
  int busy = 0;
  logic act = 1'h0, rd = 1'h0, tx = 1'h0;
  logic [7:0] sh, cmd, dat, wiper, mem = 8'h00;
  initial oe_n = 1'h1;
  // wiper comes up from the first setting
  initial wiper = mem;
  // the bench wire carries no glitches, so no filter is modelled
  ////////////////////////////////////////
  // start drops any half-received write
  always @(negedge sda) if (scl) begin
    act = 1'h1;
    n = 0;
    k = 0;
    tx = 1'h0;
    oe_n = 1'h1;
  end
  // stop after a full unprotected nonvolatile write starts programming
  always @(posedge sda) if (scl) begin
    if (act && k == 3 && !rd && wp_n && cmd[7:4] == 4'hc) begin
      busy = PROG;
      mem = dat;
    end
    // volatile wiper write takes effect at once
    if (act && k == 3 && cmd[7:4] == 4'ha) wiper = dat;
    act = 1'h0;
  end
  // programming runs on its own, bus ignored meanwhile
  always @(posedge clk) if (busy > 0) busy--;
  // bits taken msb first; master nack ends a read
  always @(posedge scl) if (act) begin
    if (n < 8) sh = {sh[6:0], sda};
    if (n == 8 && tx && sda) act = 1'h0;
    n++;
  end
  // only ever pulls low, so the wired bus stays shareable
  always @(negedge scl) if (act) begin
    if (n == 9) begin
      n = 0;
      tx = rd && k >= 2;
    end
    oe_n = 1'h1;
    if (n == 8 && !tx) begin
      if (k == 0) oe_n = !(sh == {TYPE, STRAP} && busy == 0);
      if (k == 1) oe_n = 1'h0;
      if (k == 1) rd = sh[7:4] == 4'h9 || sh[7:4] == 4'hb;
      if (k == 1) cmd = sh;
      if (k == 2) dat = sh; // kept apart: the stop clock shifts sh again
      if (k == 2) oe_n = !wp_n && cmd[7:4] == 4'hc;
      if (oe_n) act = 1'h0;
      k++;
    end
    if (tx && n < 8) oe_n = mem[7 - n];
  end
endmodule // pot_dev_model

//--- verification/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK_SYS = 1'h0, RST_N = 1'h0, WB_WE_I = 1'h0;
  logic WB_CYC_I = 1'h0, WB_STB_I = 1'h0;
  logic [7:0] WB_ADR_I = 8'h00;
  logic [31:0] WB_DAT_I = 32'h0;
  logic [3:0] WB_SEL_I = 4'hf;
  logic [31:0] q;
  wire [31:0] WB_DAT_O;
  wire WB_ACK_O, SCL_O, SCL_OE_N, SDA_O, SDA_OE_N, WP_N, dev_oe_n;
  // wired bus with pull-ups: low if anyone pulls
  wire SCL_I = SCL_OE_N;
  wire SDA_I = SDA_OE_N & dev_oe_n;
  int fails = 0;
  int samples_checked = 0;
  ////////////////////////////////////////
  pot_host_ctrl #(.PWRUP_CYCLES(200)) i_dut (.CLK_SYS, .RST_N, .WB_ADR_I,
    .WB_DAT_I, .WB_DAT_O, .WB_WE_I, .WB_SEL_I, .WB_CYC_I, .WB_STB_I,
    .WB_ACK_O, .SCL_I, .SCL_O, .SCL_OE_N, .SDA_I, .SDA_O, .SDA_OE_N, .WP_N);
  pot_dev_model i_dev (.clk(CLK_SYS), .scl(SCL_I), .sda(SDA_I),
    .wp_n(WP_N), .oe_n(dev_oe_n));
  initial forever #4 CLK_SYS = ~CLK_SYS;
  ////////////////////////////////////////
  task automatic chk(input [31:0] got, input [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one classic cycle; waits for ack, however long it takes
  task automatic wb(input [7:0] a, input [31:0] d, input w);
    @(posedge CLK_SYS);
    WB_ADR_I <= a;
    WB_DAT_I <= d;
    WB_WE_I <= w;
    WB_CYC_I <= 1'h1;
    WB_STB_I <= 1'h1;
    do @(posedge CLK_SYS); while (WB_ACK_O !== 1'h1);
    q = WB_DAT_O;
    WB_CYC_I <= 1'h0;
    WB_STB_I <= 1'h0;
  endtask
  // busy is sampled twice so a stale done cannot end the wait
  task automatic xfer(input [3:0] s, input [1:0] n, input r,
      input [15:0] t, input w);
    wb(8'h04, {16'h0, t}, 1'h1);
    wb(8'h00, {23'h0, w, 1'h1, r, n, s}, 1'h1);
    do wb(8'h08, 32'h0, 1'h0); while (q[0] !== 1'h1);
    do wb(8'h08, 32'h0, 1'h0); while (q[0] !== 1'h0);
  endtask
  ////////////////////////////////////////
  // reset values, unmapped place, not ready yet
  task automatic t_regs;
    wb(8'h08, 32'h0, 1'h0);
    chk(q[3], 1'h0);
    wb(8'h0c, 32'hffff_ffff, 1'h1);
    wb(8'h0c, 32'h0, 1'h0);
    chk(q, 32'h0);
    wb(8'h00, 32'h0, 1'h0);
    chk(q, 32'h130);
  endtask
  // nonvolatile write, then polling during and after programming
  task automatic t_write;
    xfer(4'h3, 2'h3, 1'h0, 16'hc45a, 1'h1);
    chk(q[2:1], 2'h2);
    chk(i_dev.busy > 0, 1'h1);
    chk(i_dev.mem, 8'h5a);
    xfer(4'h3, 2'h1, 1'h0, 16'h0, 1'h1);
    chk(q[1], 1'h1);
    while (i_dev.busy > 0) @(posedge CLK_SYS);
    xfer(4'h3, 2'h1, 1'h0, 16'h0, 1'h1);
    chk(q[1], 1'h0);
  endtask
  // foreign straps, then a protected write
  task automatic t_refuse;
    xfer(4'h2, 2'h1, 1'h0, 16'h0, 1'h1);
    chk(q[1], 1'h1);
    xfer(4'hb, 2'h1, 1'h0, 16'h0, 1'h1);
    chk(q[1], 1'h1);
    xfer(4'h3, 2'h3, 1'h0, 16'hc4a5, 1'h0);
    chk(q[1], 1'h1);
    chk(i_dev.busy, 32'h0);
    chk(i_dev.mem, 8'h5a);
  endtask
  // read back; master refuses the last byte and stops
  task automatic t_read;
    xfer(4'h3, 2'h3, 1'h1, 16'hb400, 1'h1);
    chk(q[15:8], 8'h5a);
    chk(q[1], 1'h0);
  endtask
  // volatile wiper write: acknowledged, nothing programmed
  task automatic t_wiper;
    xfer(4'h3, 2'h3, 1'h0, 16'ha277, 1'h1);
    chk(q[2:1], 2'h2);
    chk(i_dev.wiper, 8'h77);
    chk(i_dev.busy, 32'h0);
  endtask
  ////////////////////////////////////////
  task automatic results;
    if (fails == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // hang guard, about 1.7 times the expected run
  initial begin
    #800us;
    fails++;
    results;
  end
  initial begin
    repeat (6) @(posedge CLK_SYS);
    RST_N <= 1'h1;
    t_regs;
    t_write;
    t_refuse;
    t_read;
    t_wiper;
    results;
  end
endmodule // tb
